// ### shared/tsc_defs.svh
// Offsets, field positions, reset values and counts of the sensor configuration block.
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// Pointer address of the configuration register and its reset value.
`define TSC_CFG_PTR 8'h01
`define TSC_CFG_RESET 16'h0000
`define TSC_UNMAPPED_READ 16'h0000

// Field positions inside the configuration word.
`define TSC_RSVD_HI 15
`define TSC_RSVD_LO 11
`define TSC_HYST_HI 10
`define TSC_HYST_LO 9
`define TSC_SHDN_BIT 8
`define TSC_CRIT_LOCK_BIT 7
`define TSC_WIN_LOCK_BIT 6
`define TSC_CLEAR_BIT 5
`define TSC_STATUS_BIT 4
`define TSC_OUT_EN_BIT 3
`define TSC_CRIT_ONLY_BIT 2
`define TSC_POL_BIT 1
`define TSC_MODE_BIT 0

// Hysteresis select codes and their margins in 0.125 degree counts.
`define TSC_HYST_OFF 2'h0
`define TSC_HYST_1P5 2'h1
`define TSC_HYST_3P0 2'h2
`define TSC_HYST_6P0 2'h3
`define TSC_HYST_CNT_OFF 6'h00
`define TSC_HYST_CNT_1P5 6'h0C
`define TSC_HYST_CNT_3P0 6'h18
`define TSC_HYST_CNT_6P0 6'h30

// Fixed alert polarity: the pin is pulled low when asserted.
`define TSC_ALERT_LEVEL 1'b0

// Comparator slots used by the generate loop.
`define TSC_SLOT_UPPER 0
`define TSC_SLOT_LOWER 1
`define TSC_SLOT_CRIT 2
`define TSC_SLOTS 3

`endif

// ### shared/tsc_pkg.sv
// Types of the sensor configuration block.
package tsc_pkg;

  // State of the core clock domain.
  typedef struct packed {
    logic [1:0] hyst_sel;
    logic shutdown;
    logic crit_lock;
    logic win_lock;
    logic alert_en;
    logic crit_only;
    logic alert_mode;
    logic seen;
    logic int_evt;
    logic prev_win;
    logic alert_oe_n;
    logic [2:0] wr_sync;
    logic wr_acc;
    logic [2:0] ack_sync;
    logic ack_acc;
    logic [15:0] pub;
    logic pub_tgl;
  } tsc_core_st_t;

  // State of the link clock domain.
  typedef struct packed {
    logic [15:0] wr_data;
    logic wr_tgl;
    logic [2:0] wack_sync;
    logic wack_acc;
    logic [2:0] pub_sync;
    logic pub_acc;
    logic [15:0] rd_img;
    logic [15:0] rdata;
  } tsc_link_st_t;

  // State of one hysteresis comparator.
  typedef struct packed {
    logic above;
  } tsc_cmp_st_t;

endpackage : tsc_pkg

// ### hdl/tsc_hyst_cmp.sv
// One trip-limit comparator with hysteresis on falling temperature only.
`timescale 1ns/10ps
`include "tsc_defs.svh"

module tsc_hyst_cmp #(
  parameter int TEMP_W = 13
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Conversion result and limit, two's complement in 0.125 degree counts.
  input wire logic update,
  input wire logic signed [TEMP_W-1:0] temp,
  input wire logic signed [TEMP_W-1:0] limit,
  input wire logic [5:0] hyst_cnt,
  // Temperature has passed the limit and not yet fallen below the limit less the hysteresis margin.
  output logic above
);

  tsc_pkg::tsc_cmp_st_t s_q;
  tsc_pkg::tsc_cmp_st_t s_d;
  logic signed [TEMP_W:0] thresh;

  // Release point lies the hysteresis margin below the limit.
  assign thresh = $signed({limit[TEMP_W-1], limit}) - $signed({1'b0, TEMP_W'(hyst_cnt)});

  // Rising past the limit trips at once; release waits for the lowered threshold.
  always_comb begin
    s_d = s_q;
    if (update) begin
      if (temp > limit) begin
        s_d.above = 1'b1;
      end else if ($signed({temp[TEMP_W-1], temp}) < thresh) begin
        s_d.above = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign above = s_q.above;

endmodule : tsc_hyst_cmp

// ### hdl/tsc_config.sv
// Configuration register of the temperature sensor with alarm hysteresis and alert pin control.
`timescale 1ns/10ps
`include "tsc_defs.svh"

module tsc_config #(
  parameter int TEMP_W = 13
) (
  // Core clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Link clock and reset from the serial engine.
  input wire logic LINK_CLK,
  input wire logic LINK_RST,
  // Register access from the serial engine, link domain.
  input wire logic [7:0] LINK_PTR,
  input wire logic LINK_WR,
  input wire logic [15:0] LINK_WDATA,
  output logic [15:0] LINK_RDATA,
  output logic LINK_BUSY,
  // Conversion results and trip limits, core domain.
  input wire logic CONV_DONE,
  input wire logic signed [TEMP_W-1:0] TEMP,
  input wire logic signed [TEMP_W-1:0] UPPER_LIMIT,
  input wire logic signed [TEMP_W-1:0] LOWER_LIMIT,
  input wire logic signed [TEMP_W-1:0] CRIT_LIMIT,
  // Control for the converter and the limit registers.
  output logic CONV_EN,
  output logic CRIT_LOCKED,
  output logic WINDOW_LOCKED,
  // Open-drain alert pin.
  output logic ALERT_O,
  output logic ALERT_OE_N
);

  // Refuse widths that cannot hold the largest margin or the register.
  initial begin
    if (TEMP_W < 8 || TEMP_W > 16) begin
      $error("TEMP_W must lie between 8 and 16.");
    end
  end

  tsc_pkg::tsc_core_st_t c_q;
  tsc_pkg::tsc_core_st_t c_d;
  tsc_pkg::tsc_link_st_t l_q;
  tsc_pkg::tsc_link_st_t l_d;

  logic [`TSC_SLOTS-1:0] above;
  logic signed [TEMP_W-1:0] limits [`TSC_SLOTS];
  logic [5:0] hyst_cnt;
  logic update;
  logic win_alarm;
  logic crit_alarm;
  logic cond;
  logic alert_active;
  logic wr_event;
  logic ack_event;
  logic [15:0] wr_word;
  logic [15:0] image;

  // Maps the hysteresis select code to its margin in counts.
  function automatic logic [5:0] hyst_counts(input logic [1:0] sel);
    logic [5:0] cnt;
    cnt = `TSC_HYST_CNT_OFF;
    case (sel)
      `TSC_HYST_OFF: cnt = `TSC_HYST_CNT_OFF;
      `TSC_HYST_1P5: cnt = `TSC_HYST_CNT_1P5;
      `TSC_HYST_3P0: cnt = `TSC_HYST_CNT_3P0;
      `TSC_HYST_6P0: cnt = `TSC_HYST_CNT_6P0;
      default: cnt = `TSC_HYST_CNT_OFF;
    endcase
    return cnt;
  endfunction : hyst_counts

  // A synchronised level counts once the second and third stages agree.
  function automatic logic sync_stable(input logic [2:0] s);
    return s[1] == s[2];
  endfunction : sync_stable

  // Limit slots in comparator order.
  assign limits[`TSC_SLOT_UPPER] = UPPER_LIMIT;
  assign limits[`TSC_SLOT_LOWER] = LOWER_LIMIT;
  assign limits[`TSC_SLOT_CRIT] = CRIT_LIMIT;

  // Comparisons run only on a conversion outside shutdown, so state holds across it.
  assign hyst_cnt = hyst_counts(c_q.hyst_sel);
  assign update = CONV_DONE & ~c_q.shutdown;

  // One comparator per trip limit, all sharing the same margin.
  generate
    for (genvar i = 0; i < `TSC_SLOTS; i++) begin : g_cmp
      tsc_hyst_cmp #(
        .TEMP_W(TEMP_W)
      ) u_cmp (
        .clk(CLK),
        .rst(RST),
        .update(update),
        .temp(TEMP),
        .limit(limits[i]),
        .hyst_cnt(hyst_cnt),
        .above(above[i])
      );
    end
  endgenerate

  // Alarm conditions; below-lower is the lower comparator not yet above.
  assign win_alarm = c_q.seen & (above[`TSC_SLOT_UPPER] | ~above[`TSC_SLOT_LOWER]);
  assign crit_alarm = c_q.seen & above[`TSC_SLOT_CRIT];
  assign cond = c_q.crit_only ? crit_alarm : (win_alarm | crit_alarm);

  // Interrupt mode holds the latched event; critical stays comparator-like.
  assign alert_active = c_q.alert_mode ? (c_q.int_evt | crit_alarm) : cond;

  // Readback image: reserved, clear and polarity bits always read zero.
  always_comb begin
    image = `TSC_CFG_RESET;
    image[`TSC_RSVD_HI:`TSC_RSVD_LO] = '0;
    image[`TSC_HYST_HI:`TSC_HYST_LO] = c_q.hyst_sel;
    image[`TSC_SHDN_BIT] = c_q.shutdown;
    image[`TSC_CRIT_LOCK_BIT] = c_q.crit_lock;
    image[`TSC_WIN_LOCK_BIT] = c_q.win_lock;
    image[`TSC_CLEAR_BIT] = 1'b0;
    image[`TSC_STATUS_BIT] = alert_active & ~c_q.shutdown;
    image[`TSC_OUT_EN_BIT] = c_q.alert_en;
    image[`TSC_CRIT_ONLY_BIT] = c_q.crit_only;
    image[`TSC_POL_BIT] = `TSC_ALERT_LEVEL;
    image[`TSC_MODE_BIT] = c_q.alert_mode;
  end

  // Write toggle and publish acknowledge arriving from the link domain.
  assign wr_event = sync_stable(c_q.wr_sync) && (c_q.wr_sync[2] != c_q.wr_acc);
  assign ack_event = sync_stable(c_q.ack_sync);
  assign wr_word = l_q.wr_data; // Held stable by the handshake.

  // Core next state: register writes, alert logic and readback publishing.
  always_comb begin
    c_d = c_q;
    c_d.wr_sync = {c_q.wr_sync[1:0], l_q.wr_tgl};
    c_d.ack_sync = {c_q.ack_sync[1:0], l_q.pub_acc};
    if (ack_event) begin
      c_d.ack_acc = c_q.ack_sync[2];
    end
    if (update) begin
      c_d.seen = 1'b1;
    end
    // Register write from the host.
    if (wr_event) begin
      c_d.wr_acc = c_q.wr_sync[2];
      if (!(c_q.crit_lock || c_q.win_lock)) begin
        c_d.hyst_sel = wr_word[`TSC_HYST_HI:`TSC_HYST_LO];
        c_d.shutdown = wr_word[`TSC_SHDN_BIT];
      end
      c_d.crit_lock = c_q.crit_lock | wr_word[`TSC_CRIT_LOCK_BIT];
      c_d.win_lock = c_q.win_lock | wr_word[`TSC_WIN_LOCK_BIT];
      c_d.alert_en = wr_word[`TSC_OUT_EN_BIT];
      c_d.crit_only = wr_word[`TSC_CRIT_ONLY_BIT];
      c_d.alert_mode = wr_word[`TSC_MODE_BIT];
      if (wr_word[`TSC_CLEAR_BIT]) begin
        c_d.int_evt = 1'b0;
      end
    end
    // Window entry latches an event; a set in the clear cycle wins.
    c_d.prev_win = win_alarm;
    if (!c_q.shutdown && c_q.alert_mode && !c_q.crit_only && win_alarm && !c_q.prev_win) begin
      c_d.int_evt = 1'b1;
    end
    // Pin is released in shutdown or when the output is disabled.
    c_d.alert_oe_n = ~(c_q.alert_en & ~c_q.shutdown & alert_active);
    // Publish a new readback word only after the previous one was taken.
    if (image != c_q.pub && c_q.ack_acc == c_q.pub_tgl) begin
      c_d.pub = image;
      c_d.pub_tgl = ~c_q.pub_tgl;
    end
  end

  // Core state register.
  always_ff @(posedge CLK) begin
    if (RST) begin
      c_q <= '0;
      c_q.alert_oe_n <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // Link next state: capture writes, return readback of the mapped pointer.
  always_comb begin
    l_d = l_q;
    l_d.wack_sync = {l_q.wack_sync[1:0], c_q.wr_acc};
    l_d.pub_sync = {l_q.pub_sync[1:0], c_q.pub_tgl};
    if (sync_stable(l_q.wack_sync)) begin
      l_d.wack_acc = l_q.wack_sync[2];
    end
    if (LINK_WR && LINK_PTR == `TSC_CFG_PTR && !LINK_BUSY) begin
      l_d.wr_data = LINK_WDATA;
      l_d.wr_tgl = ~l_q.wr_tgl;
    end
    if (sync_stable(l_q.pub_sync) && l_q.pub_sync[2] != l_q.pub_acc) begin
      l_d.rd_img = c_q.pub;
      l_d.pub_acc = l_q.pub_sync[2];
    end
    l_d.rdata = (LINK_PTR == `TSC_CFG_PTR) ? l_q.rd_img : `TSC_UNMAPPED_READ;
  end

  // Link state register.
  always_ff @(posedge LINK_CLK) begin
    if (LINK_RST) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Outputs.
  assign LINK_BUSY = l_q.wr_tgl != l_q.wack_acc;
  assign LINK_RDATA = l_q.rdata;
  assign CONV_EN = ~c_q.shutdown;
  assign CRIT_LOCKED = c_q.crit_lock;
  assign WINDOW_LOCKED = c_q.win_lock;
  assign ALERT_O = `TSC_ALERT_LEVEL;
  assign ALERT_OE_N = c_q.alert_oe_n;

endmodule : tsc_config

// ### tb/tsc_config_checker.sv
// Port assertions for the sensor configuration block.
`timescale 1ns/10ps
module tsc_config_checker (
  // Core domain.
  input wire logic CLK,
  input wire logic RST,
  input wire logic CONV_EN,
  input wire logic CRIT_LOCKED,
  input wire logic ALERT_O,
  input wire logic ALERT_OE_N,
  // Link domain.
  input wire logic LINK_CLK,
  input wire logic LINK_RST,
  input wire logic [7:0] LINK_PTR,
  input wire logic LINK_WR,
  input wire logic [15:0] LINK_RDATA,
  input wire logic LINK_BUSY
);
  // Write requests that the block takes or ignores.
  sequence wr_take_s;
    LINK_WR && LINK_PTR == 8'h01 && !LINK_BUSY;
  endsequence
  sequence wr_skip_s;
    LINK_WR && LINK_PTR != 8'h01 && !LINK_BUSY;
  endsequence

  // Link side handshake and readback.
  busy_set_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
    wr_take_s |=> LINK_BUSY) else $error("busy not raised");
  busy_idle_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
    wr_skip_s |=> !LINK_BUSY) else $error("busy raised by unmapped write");
  busy_end_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
    $rose(LINK_BUSY) |-> ##[1:60] !LINK_BUSY) else $error("busy stuck");
  unmapped_zero_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
    LINK_PTR != 8'h01 |=> LINK_RDATA == 16'h0000) else $error("unmapped read not zero");
  rsvd_zero_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
    LINK_RDATA[15:11] == 5'h00) else $error("reserved bits not zero");
  clear_zero_a: assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
    LINK_RDATA[5] == 1'b0) else $error("alert clear reads one");

  // Core side pin and lock behaviour.
  pin_level_a: assert property (@(posedge CLK) disable iff (RST)
    ALERT_O == 1'b0) else $error("alert pin level wrong");
  shdn_release_a: assert property (@(posedge CLK) disable iff (RST)
    !CONV_EN [*3] |-> ALERT_OE_N) else $error("pin driven in shutdown");
  lock_hold_a: assert property (@(posedge CLK) disable iff (RST)
    CRIT_LOCKED |=> CRIT_LOCKED) else $error("lock cleared");
endmodule : tsc_config_checker

bind tsc_config tsc_config_checker u_chk (
  .CLK(CLK), .RST(RST), .CONV_EN(CONV_EN), .CRIT_LOCKED(CRIT_LOCKED),
  .ALERT_O(ALERT_O), .ALERT_OE_N(ALERT_OE_N), .LINK_CLK(LINK_CLK), .LINK_RST(LINK_RST),
  .LINK_PTR(LINK_PTR), .LINK_WR(LINK_WR), .LINK_RDATA(LINK_RDATA), .LINK_BUSY(LINK_BUSY)
);

// ### tb/tsc_link_host.sv
// Serial engine model that makes register accesses on the link side.
`timescale 1ns/10ps
module tsc_link_host (
  // Answers from the block.
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic [15:0] link_rdata,
  // Requests toward the block.
  output logic [7:0] link_ptr,
  output logic link_wr,
  output logic [15:0] link_wdata
);
  // Idle values at time zero.
  initial begin
    link_ptr = 8'h00;
    link_wr = 1'b0;
    link_wdata = 16'hA5A5;
  end

  // One word per write; data is inverted once released, then busy is awaited.
  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    int n;
    @(posedge link_clk);
    link_ptr <= ptr;
    link_wr <= 1'b1;
    link_wdata <= data;
    @(posedge link_clk);
    link_wr <= 1'b0;
    link_wdata <= ~data;
    #1;
    n = 0;
    while (link_busy !== 1'b0 && n < 100) begin
      @(posedge link_clk);
      #1;
      n++;
    end
  endtask : wr

  // Selects a register and waits for the readback crossing to settle.
  task automatic rd(input logic [7:0] ptr, output logic [15:0] data);
    @(posedge link_clk);
    link_ptr <= ptr;
    repeat (50) @(posedge link_clk);
    #1 data = link_rdata;
  endtask : rd
endmodule : tsc_link_host

// ### tb/testbench.sv
// Self-checking bench for the configuration register and its alarm hysteresis.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic link_rst = 1'b1;
  logic conv_done = 1'b0;
  logic signed [12:0] temp = 13'sh0000;
  logic signed [12:0] crit = 13'sh0320;
  logic signed [12:0] upper = 13'sh07D0;
  logic signed [12:0] lower = 13'sh1830;
  logic [7:0] ptr;
  logic wr, busy, conv_en, crit_lk, win_lk, alert_o, alert_oe_n;
  logic [15:0] wdata, rdata, rd_v, cfg;
  logic [5:0] marg [4] = '{6'h00, 6'h0C, 6'h18, 6'h30};
  int n_fail = 0;
  int n_tests = 0;

  // Core clock and an unrelated link clock.
  always #25 clk = ~clk;
  initial begin
    #2.3;
    forever #6 link_clk = ~link_clk;
  end

  tsc_config u_dut (.CLK(clk), .RST(rst), .LINK_CLK(link_clk), .LINK_RST(link_rst),
    .LINK_PTR(ptr), .LINK_WR(wr), .LINK_WDATA(wdata), .LINK_RDATA(rdata), .LINK_BUSY(busy),
    .CONV_DONE(conv_done), .TEMP(temp), .UPPER_LIMIT(upper), .LOWER_LIMIT(lower),
    .CRIT_LIMIT(crit), .CONV_EN(conv_en), .CRIT_LOCKED(crit_lk), .WINDOW_LOCKED(win_lk),
    .ALERT_O(alert_o), .ALERT_OE_N(alert_oe_n));
  tsc_link_host u_host (.link_clk(link_clk), .link_busy(busy), .link_rdata(rdata),
    .link_ptr(ptr), .link_wr(wr), .link_wdata(wdata));

  // Compares one result and counts it.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Checks the alert pin enable.
  task automatic pin(input logic e);
    chk("alert pin", {15'h0000, e}, {15'h0000, alert_oe_n});
  endtask : pin

  // Hands one conversion result over and lets the pin settle.
  task automatic conv(input logic signed [12:0] t);
    @(posedge clk);
    temp <= t;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : conv

  // Writes the configuration and lets the core apply it.
  task automatic wcfg(input logic [15:0] v);
    u_host.wr(8'h01, v);
    repeat (3) @(posedge clk);
    #1;
  endtask : wcfg

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hang short.
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  // Main sequence of register accesses and conversions.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    link_rst <= 1'b0;
    u_host.rd(8'h01, rd_v);
    chk("cfg reset", 16'h0000, rd_v);
    wcfg(16'h063A);
    u_host.rd(8'h01, rd_v);
    chk("cfg access", 16'h0608, rd_v);
    u_host.wr(8'h02, 16'h0000);
    u_host.rd(8'h02, rd_v);
    chk("unmapped", 16'h0000, rd_v);
    u_host.rd(8'h01, rd_v);
    chk("cfg kept", 16'h0608, rd_v);
    for (int c = 0; c < 4; c++) begin
      cfg = 16'h0008 | (16'(c) << 9);
      wcfg(cfg);
      conv(crit);
      pin(1'b1);
      conv(crit + 13'sh0001);
      pin(1'b0);
      u_host.rd(8'h01, rd_v);
      chk("cfg status", cfg | 16'h0010, rd_v);
      conv(crit - 13'(marg[c]));
      pin(1'b0);
      conv(crit - 13'(marg[c]) - 13'sh0001);
      pin(1'b1);
    end
    wcfg(16'h0008);
    conv(crit + 13'sh0001);
    wcfg(16'h0108);
    chk("conv en", 16'h0000, {15'h0000, conv_en});
    pin(1'b1);
    conv(13'sh0000);
    wcfg(16'h0008);
    pin(1'b0);
    conv(13'sh0000);
    pin(1'b1);
    wcfg(16'h02C8);
    wcfg(16'h0708);
    u_host.rd(8'h01, rd_v);
    chk("locked cfg", 16'h02C8, rd_v);
    chk("locks", 16'h0003, {14'h0000, crit_lk, win_lk});
    // Interrupt mode latches a window entry until the alert clear bit is written.
    wcfg(16'h0009);
    conv(lower - 13'sh0020);
    pin(1'b0);
    conv(13'sh0000);
    pin(1'b0);
    wcfg(16'h0029);
    pin(1'b1);
    u_host.rd(8'h01, rd_v);
    chk("cleared cfg", 16'h02C9, rd_v);
    // Critical-only mode keeps a window alarm off the pin.
    wcfg(16'h000C);
    conv(lower - 13'sh0020);
    pin(1'b1);
    u_host.rd(8'h01, rd_v);
    chk("crit only cfg", 16'h02CC, rd_v);
    wcfg(16'h0008);
    pin(1'b0);
    chk("alert level", 16'h0000, {15'h0000, alert_o});
    give_verdict();
  end
endmodule : testbench
